// >>> core/pclsc_chan.sv
// One pulse output channel: start, ramp, limit stop, halt and position count.
`timescale 1ns/10ps
module pclsc_chan #(
    parameter logic [15:0] FAST = pclsc_pkg::FAST_PERIOD,
    parameter logic [15:0] SLOW = pclsc_pkg::SLOW_PERIOD,
    parameter logic [15:0] STEP = pclsc_pkg::PERIOD_STEP
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Command and flags from the register file.
    input pclsc_pkg::pclsc_chan_in_type chan_in,
    // Pulse train and direction towards the drive.
    output logic pulse,
    output logic dir_fwd,
    // Observed state for status reads.
    output pclsc_pkg::pclsc_chan_out_type chan_out
);

    typedef struct packed {
        pclsc_pkg::pclsc_state_type st;
        logic [2:0] cmd;
        logic ramp;
        logic dir_fwd;
        logic pulse;
        logic [15:0] period;
        logic [15:0] cnt;
        logic [pclsc_pkg::POS_W-1:0] position;
    } pclsc_chan_state_type;

    pclsc_chan_state_type s;
    pclsc_chan_state_type next_s;
    logic lim_hit;
    logic wrap;
    logic start_ramp;
    logic stop_req;

    // Next state; the halt test comes first so it overrides any ramp.
    always_comb begin
        next_s = s;
        lim_hit = s.dir_fwd ? chan_in.fwd_limit : chan_in.rev_limit;
        wrap = (s.cnt == s.period - 16'h0001);
        start_ramp = (chan_in.cmd_code != pclsc_pkg::CMD_VSPEED) || chan_in.ramp_en;
        stop_req = lim_hit || !chan_in.cmd_on;
        unique case (s.st)
            pclsc_pkg::ST_IDLE: begin
                next_s.pulse = 1'b0;
                next_s.cnt = '0;
                if (chan_in.enable && chan_in.cmd_on) begin
                    next_s.cmd = chan_in.cmd_code;
                    next_s.ramp = start_ramp;
                    next_s.period = start_ramp ? SLOW : FAST;
                    if (chan_in.cmd_code == pclsc_pkg::CMD_PLAIN_HOME) begin
                        next_s.dir_fwd = 1'b0;
                    end else if (chan_in.cmd_code == pclsc_pkg::CMD_SEARCH_HOME) begin
                        next_s.dir_fwd = chan_in.home_fwd;
                    end else begin
                        next_s.dir_fwd = chan_in.drive_fwd;
                    end
                    if (chan_in.cmd_code == pclsc_pkg::CMD_SEARCH_HOME && !chan_in.limits_present) begin
                        next_s.st = pclsc_pkg::ST_STOPPED;
                    end else begin
                        next_s.st = pclsc_pkg::ST_RUN;
                    end
                end
            end
            pclsc_pkg::ST_RUN, pclsc_pkg::ST_DECEL: begin
                if (chan_in.halt) begin
                    next_s.st = pclsc_pkg::ST_HALTED;
                    next_s.pulse = 1'b0;
                end else if (s.st == pclsc_pkg::ST_RUN && stop_req && !s.ramp) begin
                    next_s.pulse = 1'b0;
                    next_s.st = chan_in.cmd_on ? pclsc_pkg::ST_STOPPED : pclsc_pkg::ST_IDLE;
                end else begin
                    next_s.cnt = wrap ? 16'h0000 : s.cnt + 16'h0001;
                    if (s.cnt == 16'h0000) begin
                        next_s.pulse = 1'b1;
                        next_s.position = s.dir_fwd ? s.position + 16'h0001 : s.position - 16'h0001;
                    end else if (s.cnt == (s.period >> 1)) begin
                        next_s.pulse = 1'b0;
                    end
                    // Only the channel's own flags end a run; the drive's limits are not seen.
                    if (s.st == pclsc_pkg::ST_RUN && stop_req) begin
                        next_s.st = pclsc_pkg::ST_DECEL;
                    end else if (wrap && s.st == pclsc_pkg::ST_RUN && s.period > FAST) begin
                        next_s.period = s.period - STEP;
                    end else if (wrap && s.st == pclsc_pkg::ST_DECEL) begin
                        if (s.period >= SLOW) begin
                            next_s.pulse = 1'b0;
                            next_s.st = chan_in.cmd_on ? pclsc_pkg::ST_STOPPED : pclsc_pkg::ST_IDLE;
                        end else begin
                            next_s.period = s.period + STEP;
                        end
                    end
                end
            end
            pclsc_pkg::ST_STOPPED: begin
                if (!chan_in.cmd_on) begin
                    next_s.st = pclsc_pkg::ST_IDLE;
                end
            end
            pclsc_pkg::ST_HALTED: begin
                if (!chan_in.halt && !chan_in.cmd_on) begin
                    next_s.st = pclsc_pkg::ST_IDLE;
                end
            end
            default: begin
                next_s.st = pclsc_pkg::ST_IDLE;
                next_s.pulse = 1'b0;
            end
        endcase
        // A channel without its adapter never leaves idle.
        if (!chan_in.enable) begin
            next_s.st = pclsc_pkg::ST_IDLE;
            next_s.pulse = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pulse = s.pulse;
    assign dir_fwd = s.dir_fwd;
    assign chan_out = '{st: s.st, cmd: s.cmd, ramp: s.ramp, dir_fwd: s.dir_fwd, position: s.position};

endmodule // pclsc_chan

// >>> core/pclsc_pkg.sv
// Constants, types and the overview of operation for the pulse channel limit and stop control.
//
// Overview of operation
// - Variable speed without ramp stops pulses at once on matching limit or command off.
// - Homing, feed, drive and ramped variable speed decelerate then stop on matching limit.
// - Setting the halt flag while pulsing stops pulse output at once, no ramp.
// - After a halt, clear the flag, then drop and raise the command to pulse again.
// - Stops caused only by amplifier limits go unseen; pulses continue until command off.
// - Dog-search homing is unavailable when first-level limit flags are not provided.
// - On older controller versions variable speed always runs without ramping.
// - Turning the command off gives a normal decelerated stop on ramped commands.
// - Homing direction depends on the command; dog-search homes towards its first movement.
// - Plain homing moves only in reverse, counting the current position down.
// - For dog-search homing a set direction flag homes forward, a clear one reverse.
package pclsc_pkg;

    localparam int unsigned NUM_CH = 4;
    localparam int unsigned POS_W = 16;

    // Register byte offsets; every aligned word from OFS_CTRL to OFS_LAST is mapped.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LIMIT = 8'h04;
    localparam logic [7:0] OFS_HALT = 8'h08;
    localparam logic [7:0] OFS_HOMEDIR = 8'h0c;
    localparam logic [7:0] OFS_CMD0 = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_POS0 = 8'h24;
    localparam logic [7:0] OFS_LAST = 8'h30;

    // Control register bit positions.
    localparam int unsigned CTRL_RAMP_BIT = 0;
    localparam int unsigned CTRL_LEGACY_BIT = 1;
    localparam int unsigned CTRL_DUAL_BIT = 2;
    localparam int unsigned CTRL_LIMITS_BIT = 3;

    // Command register fields.
    localparam int unsigned CMD_CODE_LSB = 0;
    localparam int unsigned CMD_DIR_BIT = 3;
    localparam int unsigned CMD_ON_BIT = 4;

    // Status register field positions, one bit per channel in each group.
    localparam int unsigned STAT_BUSY_LSB = 0;
    localparam int unsigned STAT_HALTED_LSB = 4;
    localparam int unsigned STAT_STOPPED_LSB = 8;
    localparam int unsigned STAT_DIR_LSB = 12;

    // Values after reset.
    localparam logic [3:0] RST_CTRL = 4'h0;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam logic [4:0] RST_CMD = 5'h00;

    // Pulse periods in clock cycles and the ramp step per pulse.
    localparam logic [15:0] FAST_PERIOD = 16'h000a;
    localparam logic [15:0] SLOW_PERIOD = 16'h0028;
    localparam logic [15:0] PERIOD_STEP = 16'h0002;

    typedef enum logic [2:0] {
        CMD_VSPEED, CMD_SEARCH_HOME, CMD_PLAIN_HOME, CMD_INT_FEED, CMD_REL_DRIVE, CMD_ABS_DRIVE
    } pclsc_cmd_type;

    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_STOPPED, ST_HALTED} pclsc_state_type;

    typedef struct packed {
        logic enable;
        logic cmd_on;
        logic [2:0] cmd_code;
        logic drive_fwd;
        logic fwd_limit;
        logic rev_limit;
        logic halt;
        logic home_fwd;
        logic ramp_en;
        logic limits_present;
    } pclsc_chan_in_type;

    typedef struct packed {
        pclsc_state_type st;
        logic [2:0] cmd;
        logic ramp;
        logic dir_fwd;
        logic [POS_W-1:0] position;
    } pclsc_chan_out_type;

endpackage

// >>> core/pclsc_top.sv
// APB register file and four pulse channels with limit and halt stop control.
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module pclsc_top (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pulse trains towards the drives.
    output logic pulse_channel_0,
    output logic pulse_channel_1,
    output logic pulse_channel_2,
    output logic pulse_channel_3,
    // Rotation direction, high for forward.
    output logic rotation_fwd_0,
    output logic rotation_fwd_1,
    output logic rotation_fwd_2,
    output logic rotation_fwd_3
);

    typedef struct packed {
        logic [3:0] ctrl;
        logic [3:0] fwd_limit_flag;
        logic [3:0] rev_limit_flag;
        logic [3:0] halt_flag;
        logic [3:0] homing_dir_flag;
        logic [3:0][4:0] cmd;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pclsc_top_state_type;

    pclsc_top_state_type s;
    pclsc_top_state_type next_s;
    pclsc_pkg::pclsc_chan_in_type [3:0] ch_in;
    pclsc_pkg::pclsc_chan_out_type [3:0] ch_out;
    logic [3:0] pulse_bus;
    logic [3:0] dir_bus;
    logic setup;
    logic access;

    // Every aligned word up to the last offset is mapped; anything else answers with an error.
    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a[1:0] == 2'b00) && (a <= pclsc_pkg::OFS_LAST);
    endfunction

    // Read multiplexer; unmapped and reserved bits read as zero.
    function automatic logic [31:0] read_word(input pclsc_top_state_type r,
                                              input pclsc_pkg::pclsc_chan_out_type [3:0] co,
                                              input logic [7:0] a);
        logic [31:0] w;
        logic [7:0] d;
        w = '0;
        d = a - pclsc_pkg::OFS_POS0;
        if (!addr_mapped(a)) begin
            w = '0;
        end else if (a == pclsc_pkg::OFS_CTRL) begin
            w[3:0] = r.ctrl;
        end else if (a == pclsc_pkg::OFS_LIMIT) begin
            w[7:0] = {r.rev_limit_flag, r.fwd_limit_flag};
        end else if (a == pclsc_pkg::OFS_HALT) begin
            w[3:0] = r.halt_flag;
        end else if (a == pclsc_pkg::OFS_HOMEDIR) begin
            w[3:0] = r.homing_dir_flag;
        end else if (a < pclsc_pkg::OFS_STATUS) begin
            w[4:0] = r.cmd[a[3:2]];
        end else if (a == pclsc_pkg::OFS_STATUS) begin
            for (int i = 0; i < 4; i++) begin
                w[pclsc_pkg::STAT_BUSY_LSB + i] = (co[i].st == pclsc_pkg::ST_RUN) ||
                                                  (co[i].st == pclsc_pkg::ST_DECEL);
                w[pclsc_pkg::STAT_HALTED_LSB + i] = (co[i].st == pclsc_pkg::ST_HALTED);
                w[pclsc_pkg::STAT_STOPPED_LSB + i] = (co[i].st == pclsc_pkg::ST_STOPPED);
                w[pclsc_pkg::STAT_DIR_LSB + i] = co[i].dir_fwd;
            end
        end else begin
            w[15:0] = co[d[3:2]].position;
        end
        read_word = w;
    endfunction

    assign setup = psel && !penable;
    assign access = psel && penable && s.pready;

    // Register file and APB answer; the answer is ready in the first access cycle.
    always_comb begin
        next_s = s;
        next_s.pready = setup;
        next_s.pslverr = setup && !addr_mapped(paddr);
        if (setup) begin
            next_s.prdata = pwrite ? 32'h0000_0000 : read_word(s, ch_out, paddr);
        end
        if (access && pwrite && addr_mapped(paddr)) begin
            if (paddr == pclsc_pkg::OFS_CTRL) begin
                next_s.ctrl = pwdata[3:0];
            end else if (paddr == pclsc_pkg::OFS_LIMIT) begin
                next_s.fwd_limit_flag = pwdata[3:0];
                next_s.rev_limit_flag = pwdata[7:4];
            end else if (paddr == pclsc_pkg::OFS_HALT) begin
                next_s.halt_flag = pwdata[3:0];
            end else if (paddr == pclsc_pkg::OFS_HOMEDIR) begin
                next_s.homing_dir_flag = pwdata[3:0];
            end else if (paddr >= pclsc_pkg::OFS_CMD0 && paddr < pclsc_pkg::OFS_STATUS) begin
                next_s.cmd[paddr[3:2]] = pwdata[4:0];
            end
        end
    end

    // State register, including the APB answer flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s.ctrl <= pclsc_pkg::RST_CTRL;
            s.fwd_limit_flag <= pclsc_pkg::RST_FLAGS;
            s.rev_limit_flag <= pclsc_pkg::RST_FLAGS;
            s.halt_flag <= pclsc_pkg::RST_FLAGS;
            s.homing_dir_flag <= pclsc_pkg::RST_FLAGS;
            s.cmd <= {4{pclsc_pkg::RST_CMD}};
            s.prdata <= 32'h0000_0000;
            s.pready <= 1'b0;
            s.pslverr <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // Channel inputs; the last channel is enabled only with both adapters fitted.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ch
            assign ch_in[gi].enable = (gi < 3) ? 1'b1 : s.ctrl[pclsc_pkg::CTRL_DUAL_BIT];
            assign ch_in[gi].cmd_on = s.cmd[gi][pclsc_pkg::CMD_ON_BIT];
            assign ch_in[gi].cmd_code = s.cmd[gi][pclsc_pkg::CMD_CODE_LSB +: 3];
            assign ch_in[gi].drive_fwd = s.cmd[gi][pclsc_pkg::CMD_DIR_BIT];
            assign ch_in[gi].fwd_limit = s.fwd_limit_flag[gi];
            assign ch_in[gi].rev_limit = s.rev_limit_flag[gi];
            assign ch_in[gi].halt = s.halt_flag[gi];
            assign ch_in[gi].home_fwd = s.homing_dir_flag[gi];
            // Older controllers ignore the ramp flag, so variable speed never ramps there.
            assign ch_in[gi].ramp_en = s.ctrl[pclsc_pkg::CTRL_RAMP_BIT] &&
                                       !s.ctrl[pclsc_pkg::CTRL_LEGACY_BIT];
            assign ch_in[gi].limits_present = s.ctrl[pclsc_pkg::CTRL_LIMITS_BIT];

            pclsc_chan u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .chan_in(ch_in[gi]),
                .pulse(pulse_bus[gi]),
                .dir_fwd(dir_bus[gi]),
                .chan_out(ch_out[gi])
            );
        end
    endgenerate

    // Outputs come from the register flops and the channel flops directly.
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign pulse_channel_0 = pulse_bus[0];
    assign pulse_channel_1 = pulse_bus[1];
    assign pulse_channel_2 = pulse_bus[2];
    assign pulse_channel_3 = pulse_bus[3];
    assign rotation_fwd_0 = dir_bus[0];
    assign rotation_fwd_1 = dir_bus[1];
    assign rotation_fwd_2 = dir_bus[2];
    assign rotation_fwd_3 = dir_bus[3];

    // Checks on channel 0, on the APB answer and on the adapter gating of channel 3.
    localparam int DECEL_MAX = 700;
    logic c0_idle;
    logic c0_run;
    logic c0_decel;
    logic c0_halted;
    logic c0_lim;
    logic c0_start;

    assign c0_idle = ch_out[0].st == pclsc_pkg::ST_IDLE;
    assign c0_run = ch_out[0].st == pclsc_pkg::ST_RUN;
    assign c0_decel = ch_out[0].st == pclsc_pkg::ST_DECEL;
    assign c0_halted = ch_out[0].st == pclsc_pkg::ST_HALTED;
    assign c0_lim = ch_out[0].dir_fwd ? ch_in[0].fwd_limit : ch_in[0].rev_limit;
    assign c0_start = c0_idle && ch_in[0].cmd_on;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_noramp_limit_stop: assert property (
        c0_run && !ch_in[0].halt && (c0_lim || !ch_in[0].cmd_on) && !ch_out[0].ramp
        |=> !pulse_bus[0] && (ch_out[0].st inside {pclsc_pkg::ST_STOPPED, pclsc_pkg::ST_IDLE}))
        else $error("variable speed without ramp did not stop at once");

    a_ramp_limit_decel: assert property (
        c0_run && !ch_in[0].halt && c0_lim && ch_out[0].ramp |=> c0_decel)
        else $error("ramped command did not decelerate on limit");

    a_decel_bounded: assert property (
        c0_decel |-> ##[1:DECEL_MAX] !c0_decel)
        else $error("deceleration did not end in time");

    a_halt_immediate: assert property (
        (c0_run || c0_decel) && ch_in[0].halt |=> c0_halted && !pulse_bus[0])
        else $error("halt did not stop pulses at once");

    a_halt_release: assert property (
        c0_halted && (ch_in[0].halt || ch_in[0].cmd_on) |=> c0_halted && !pulse_bus[0])
        else $error("halted channel left halt too early");

    a_keep_pulsing: assert property (
        c0_run && ch_in[0].cmd_on && !ch_in[0].halt && !c0_lim |=> c0_run)
        else $error("channel stopped without its own stop cause");

    a_dog_refused: assert property (
        c0_start && ch_in[0].cmd_code == pclsc_pkg::CMD_SEARCH_HOME && !ch_in[0].limits_present
        |=> ch_out[0].st == pclsc_pkg::ST_STOPPED ##1 !pulse_bus[0])
        else $error("dog search ran without limit flags");

    a_legacy_noramp: assert property (
        c0_start && s.ctrl[pclsc_pkg::CTRL_LEGACY_BIT] && ch_in[0].cmd_code == pclsc_pkg::CMD_VSPEED
        |=> !ch_out[0].ramp)
        else $error("variable speed ramped on an old controller");

    a_fourth_idle: assert property (
        !s.ctrl[pclsc_pkg::CTRL_DUAL_BIT] |=> ch_out[3].st == pclsc_pkg::ST_IDLE && !pulse_bus[3])
        else $error("fourth channel ran without both adapters");

    a_off_decel: assert property (
        c0_run && !ch_in[0].halt && !ch_in[0].cmd_on && ch_out[0].ramp |=> c0_decel)
        else $error("command off did not decelerate");

    a_search_dir: assert property (
        c0_start && ch_in[0].cmd_code == pclsc_pkg::CMD_SEARCH_HOME && ch_in[0].limits_present
        |=> c0_run && ch_out[0].dir_fwd == $past(ch_in[0].home_fwd))
        else $error("dog search homing direction wrong");

    a_plain_reverse: assert property (
        c0_start && ch_in[0].cmd_code == pclsc_pkg::CMD_PLAIN_HOME |=> !ch_out[0].dir_fwd [*2])
        else $error("plain homing not in reverse");

    a_plain_count_down: assert property (
        $rose(pulse_bus[0]) && ch_out[0].cmd == pclsc_pkg::CMD_PLAIN_HOME
        |-> ch_out[0].position == $past(ch_out[0].position) - 16'h0001)
        else $error("plain homing did not count down");

    a_halt_priority: assert property (
        c0_run && ch_in[0].halt && c0_lim |=> c0_halted)
        else $error("limit deceleration beat the halt");

    a_apb_error: assert property (
        setup && !addr_mapped(paddr) |=> pready && pslverr)
        else $error("unmapped address not refused");

    a_apb_one_access: assert property (
        setup |=> pready ##1 !pready)
        else $error("register answer was not a single cycle");

    a_idle_quiet: assert property (
        c0_idle |-> !pulse_bus[0])
        else $error("idle channel emitted a pulse");

    a_stop_quiet: assert property (
        ch_out[0].st == pclsc_pkg::ST_STOPPED |-> !pulse_bus[0])
        else $error("stopped channel emitted a pulse");

    a_unramped_start: assert property (
        c0_start && ch_in[0].cmd_code == pclsc_pkg::CMD_VSPEED && !ch_in[0].ramp_en |=> !ch_out[0].ramp)
        else $error("variable speed ramped with ramping off");

    // Halt and limit meeting in one run cycle is the corner the priority logic exists for.
    c_halt_first: cover property (c0_run && ch_in[0].halt && c0_lim);
    c_halt_stop: cover property (c0_run ##1 c0_halted);
    c_decel_stop: cover property (c0_decel ##1 ch_out[0].st == pclsc_pkg::ST_STOPPED);
    c_noramp_stop: cover property (c0_run && !ch_out[0].ramp && c0_lim ##1 !c0_run);
    c_search_run: cover property (c0_start && ch_in[0].cmd_code == pclsc_pkg::CMD_SEARCH_HOME ##1 c0_run);

endmodule // pclsc_top

// >>> tb/pclsc_drive_model.sv
// Drive model that counts received pulses and tracks position per channel.
`timescale 1ns/10ps
module pclsc_drive_model (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Pulse trains and directions from the block.
    input wire logic [3:0] pulse,
    input wire logic [3:0] fwd,
    // Pulses seen and position per channel.
    output logic [3:0][15:0] edges,
    output logic [3:0][15:0] pos
);
    logic [3:0] last;
    // The drive steps on each rising pulse edge; it never stops on its own, so pulses always land.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 4'h0;
            edges <= '0;
            pos <= '0;
        end else begin
            last <= pulse;
            for (int i = 0; i < 4; i++) begin
                if (pulse[i] && !last[i]) begin
                    edges[i] <= edges[i] + 16'h0001;
                    pos[i] <= fwd[i] ? pos[i] + 16'h0001 : pos[i] - 16'h0001;
                end
            end
        end
    end
endmodule // pclsc_drive_model

// >>> tb/pclsc_tb_top.sv
// Self-checking bench for the limit and halt stop control.
`timescale 1ns/10ps
module pclsc_tb_top;
    typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic e;} pclsc_row_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pulse, fwd;
    logic [3:0][15:0] edges, pos;
    int failures, checks, cycles;
    logic [31:0] k;
    pclsc_row_type rows [8];
    pclsc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pulse_channel_0(pulse[0]), .pulse_channel_1(pulse[1]), .pulse_channel_2(pulse[2]),
        .pulse_channel_3(pulse[3]), .rotation_fwd_0(fwd[0]), .rotation_fwd_1(fwd[1]),
        .rotation_fwd_2(fwd[2]), .rotation_fwd_3(fwd[3]));
    pclsc_drive_model u_drive (.pclk(pclk), .presetn(presetn), .pulse(pulse), .fwd(fwd),
        .edges(edges), .pos(pos));
    // Clock of 100 ns period.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Hang guard; the tests need well under a third of this.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            results();
        end
    end
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask
    // The answer is taken at the rising edge where pready is high, or after 50 edges without it; the request is released then.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ok;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            ok = (pready === 1'b1);
            n++;
        end while (!ok && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) failures++;
    endtask
    task automatic cmd(input int c, input logic [4:0] v);
        apb(1'b1, 8'(8'h10 + 4 * c), {27'h0, v});
    endtask
    task automatic count(input int c, input int n);
        k = 32'(edges[c]);
        repeat (n) @(posedge pclk);
        k = 32'(edges[c]) - k;
    endtask
    task automatic results();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Main sequence: register rows, then the stop cases.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, failures, checks, cycles} = '0;
        rows = '{'{8'h04, 32'hffffffff, 32'hff, 1'b0}, '{8'h04, 32'h0, 32'h0, 1'b0},
            '{8'h08, 32'hffffffff, 32'hf, 1'b0}, '{8'h08, 32'h0, 32'h0, 1'b0},
            '{8'h0c, 32'ha5, 32'h5, 1'b0}, '{8'h0c, 32'h0, 32'h0, 1'b0},
            '{8'h34, 32'h1, 32'h0, 1'b1}, '{8'h02, 32'h1, 32'h0, 1'b1}};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        check("idle pulses", {28'h0, pulse}, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            apb(1'b0, rows[i].a, 32'h0);
            check("read back", rd, rows[i].r);
            check("error flag", {31'h0, er}, {31'h0, rows[i].e});
        end
        // Unramped, then legacy with ramp requested: a matching limit cuts pulses at once.
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, 8'h00, m ? 32'h3 : 32'h0);
            cmd(0, m ? 5'h10 : 5'h18);
            count(0, 60);
            check("ch0 run", 32'(k != 0), 32'h1);
            apb(1'b1, 8'h04, m ? 32'h10 : 32'h01);
            repeat (2) @(posedge pclk);
            check("ch0 stop", {31'h0, pulse[0]}, 32'h0);
            count(0, 60);
            check("ch0 quiet", k, 32'h0);
            cmd(0, 5'h00);
            apb(1'b1, 8'h04, 32'h0);
        end
        // Halt and a matching limit both present when the run begins: the halt must win.
        apb(1'b1, 8'h04, 32'h01);
        apb(1'b1, 8'h08, 32'h01);
        cmd(0, 5'h18);
        count(0, 40);
        check("ch0 halt first", k, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check("ch0 halted", 32'(rd[4]), 32'h1);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h04, 32'h0);
        cmd(0, 5'h00);
        // Each homing, feed and drive command decelerates on its matching limit and then holds.
        apb(1'b1, 8'h00, 32'h9);
        for (int c = 1; c < 6; c++) begin
            cmd(1, 5'(5'h18 + c));
            repeat (200) @(posedge pclk);
            check("ch1 dir", {31'h0, fwd[1]}, {31'h0, c > 2});
            apb(1'b1, 8'h04, c > 2 ? 32'h02 : 32'h20);
            count(1, 30);
            check("ch1 decel", 32'(k != 0), 32'h1);
            repeat (700) @(posedge pclk);
            apb(1'b0, 8'h20, 32'h0);
            check("ch1 stopped", 32'(rd[9]), 32'h1);
            count(1, 60);
            check("ch1 held", k, 32'h0);
            apb(1'b0, 8'h28, 32'h0);
            check("ch1 position", rd, {16'h0, pos[1]});
            cmd(1, 5'h00);
            apb(1'b1, 8'h04, 32'h0);
        end
        cmd(1, 5'h1c);
        repeat (200) @(posedge pclk);
        cmd(1, 5'h00);
        count(1, 30);
        check("ch1 off ramp", 32'(k != 0), 32'h1);
        repeat (700) @(posedge pclk);
        // Halt during deceleration wins; restart needs halt clear and a command toggle.
        cmd(2, 5'h1c);
        repeat (100) @(posedge pclk);
        apb(1'b1, 8'h04, 32'h04);
        apb(1'b1, 8'h08, 32'h04);
        repeat (2) @(posedge pclk);
        check("ch2 halt", {31'h0, pulse[2]}, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check("ch2 halted", 32'(rd[6]), 32'h1);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h04, 32'h0);
        count(2, 100);
        check("ch2 held", k, 32'h0);
        cmd(2, 5'h00);
        cmd(2, 5'h1c);
        count(2, 100);
        check("ch2 again", 32'(k != 0), 32'h1);
        cmd(2, 5'h00);
        // Search homing without limit flags, and the fourth channel without adapters.
        apb(1'b1, 8'h00, 32'h0);
        cmd(0, 5'h11);
        cmd(3, 5'h1c);
        count(0, 100);
        check("no search", k, 32'h0);
        count(3, 100);
        check("ch3 off", k, 32'h0);
        apb(1'b1, 8'h00, 32'h4);
        count(3, 100);
        check("ch3 on", 32'(k != 0), 32'h1);
        results();
    end
endmodule // pclsc_tb_top
